// >>> design/tfp_pkg.sv
package tfp_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] COUNTER_OFFSET  = 8'h04;
  localparam logic [7:0] COMPARE_A_OFFSET = 8'h08;
  localparam logic [7:0] COMPARE_B_OFFSET = 8'h0C;
  localparam logic [7:0] CAPTURE_OFFSET  = 8'h10;
  localparam logic [7:0] FLAGS_OFFSET    = 8'h14;

  // flag bit positions
  localparam int FLAG_OVERFLOW  = 0;
  localparam int FLAG_COMPARE_A = 1;
  localparam int FLAG_COMPARE_B = 2;
  localparam int FLAG_CAPTURE   = 3;

  // waveform mode codes
  localparam logic [3:0] MODE_PHASE_8   = 4'h1;
  localparam logic [3:0] MODE_PHASE_9   = 4'h2;
  localparam logic [3:0] MODE_PHASE_10  = 4'h3;
  localparam logic [3:0] MODE_FAST_8    = 4'h5;
  localparam logic [3:0] MODE_FAST_9    = 4'h6;
  localparam logic [3:0] MODE_FAST_10   = 4'h7;
  localparam logic [3:0] MODE_PHASE_CAP = 4'hA;
  localparam logic [3:0] MODE_PHASE_OCA = 4'hB;
  localparam logic [3:0] MODE_FAST_CAP  = 4'hE;
  localparam logic [3:0] MODE_FAST_OCA  = 4'hF;

  // fixed top values
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // compare output mode codes
  localparam logic [1:0] COM_OFF      = 2'h0;
  localparam logic [1:0] COM_TOGGLE   = 2'h1;
  localparam logic [1:0] COM_NONINV   = 2'h2;
  localparam logic [1:0] COM_INVERTED = 2'h3;

  // clock select codes and prescaler masks
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  typedef struct packed {
    logic       dir_b;
    logic       dir_a;
    logic [2:0] clock_select;
    logic [1:0] channel_b_output_mode;
    logic [1:0] channel_a_output_mode;
    logic [3:0] waveform_mode_select;
  } tfp_ctrl_type;

  localparam tfp_ctrl_type CTRL_RESET = 13'h0000;
  localparam logic [15:0]  WORD_RESET = 16'h0000;

endpackage

// >>> design/tfp_timer16.sv
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Function
// R1: modes 5,6,7,14,15 count up from zero to top, then restart at zero.
// R2: single-slope top is 0x00FF, 0x01FF, 0x03FF, capture top, or compare A.
// R3: single-slope counter at top clears on the next timer tick.
// R4: single-slope non-inverting sets on match, clears at wrap; inverting reversed.
// R5: output mode 2 gives non-inverted, 3 inverted pwm, both families.
// R6: single-slope overflow flag at top; compare A or capture flag same tick.
// R7: compare A writes buffered; active value loads at top with clear and overflow.
// R8: capture top acts at once; writing below count wraps through 0xFFFF first.
// R9: fixed-top modes mask compare write bits above the resolution width.
// R10: compare flag set on each timer tick in the pwm modes when counter equals that channel's compare value.
// R11: compare zero gives one-tick spike per period; compare top a constant level.
// R12: mode 15 with channel A mode 1 toggles A on match, square wave.
// R13: modes 1,2,3 fixed, 10 capture, 11 compare A top, dual-slope counting.
// R14: dual-slope counter holds top exactly one tick before counting down.
// R15: dual-slope non-inverting clears on up match, sets on down; inverting reversed.
// R16: dual-slope overflow at zero; compare A or capture flag at top.
// R17: dual-slope compare registers load buffers at top with the top flag.
// R18: dual-slope compare zero gives constant low, top constant high, non-inverted.
// R19: mode 11 with channel A mode 1 toggles A on each match.
// R20: software keeps top at least 0x0003 and not below compare values.
// R21: compare output reaches the pin only while its direction bit is output.
// R22: counter advances only on prescaler tick, divide 1, 8, 64, 256, 1024.
// R23: output mode 0 leaves the compare output register unchanged on matches.
// R24: reset clears the compare output register.
// R25: flags stay set until software clears them.
module tfp_timer16 #(
  parameter int COUNTER_WIDTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        compare_output_a_pin,
  output var  logic        compare_output_a_oe,
  output var  logic        compare_output_b_pin,
  output var  logic        compare_output_b_oe
);

  if (COUNTER_WIDTH != 16)
  begin : width_check
    $error("tfp_timer16 supports a 16-bit counter only");
  end

  tfp_pkg::tfp_ctrl_type ctrl;
  tfp_pkg::tfp_ctrl_type next_ctrl;
  logic [15:0] counter_value;
  logic [15:0] next_counter_value;
  logic        count_down;
  logic        next_count_down;
  logic [15:0] compare_buf_a;
  logic [15:0] next_compare_buf_a;
  logic [15:0] compare_buf_b;
  logic [15:0] next_compare_buf_b;
  logic [15:0] compare_value_a;
  logic [15:0] next_compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] next_compare_value_b;
  logic [15:0] capture_top_register;
  logic [15:0] next_capture_top_register;
  logic [3:0]  flags;
  logic [3:0]  next_flags;
  logic        compare_output_a;
  logic        next_compare_output_a;
  logic        compare_output_b;
  logic        next_compare_output_b;
  logic [9:0]  prescale;
  logic [9:0]  next_prescale;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_pin_a;
  logic        next_pin_b;

  logic        tick;
  logic        single_slope;
  logic        dual_slope;
  logic        fixed_top;
  logic [15:0] top;
  logic        at_top;
  logic        match_a;
  logic        match_b;
  logic        up_phase;
  logic        wr;
  logic        setup;
  logic        mapped;
  logic [15:0] write_mask;
  logic [31:0] read_word;

  // one channel's output action for the current tick
  function automatic logic wave(
    input logic       oc,
    input logic [1:0] com,
    input logic       match,
    input logic       single,
    input logic       wrap,
    input logic       up,
    input logic       toggle_ok
  );
    logic result;
    result = oc;
    if (com == tfp_pkg::COM_TOGGLE)
    begin
      if (toggle_ok && match)
        result = ~oc;  // see R12 see R19
    end
    else if (com == tfp_pkg::COM_NONINV || com == tfp_pkg::COM_INVERTED)
    begin
      if (single)
      begin
        // match at top wins over the wrap so compare equal to top stays level
        if (match)
          result = 1'b1;  // see R4 see R11
        else if (wrap)
          result = 1'b0;  // see R4
      end
      else if (match)
      begin
        result = up ? 1'b0 : 1'b1;  // see R15 see R18
      end
      if (com == tfp_pkg::COM_INVERTED && (match || (single && wrap)))
        result = ~result;  // see R5
    end
    return result;  // see R23
  endfunction

  always_comb
  begin
    single_slope = 1'b0;
    dual_slope   = 1'b0;
    fixed_top    = 1'b0;
    top          = tfp_pkg::COUNT_MAX;
    unique case (ctrl.waveform_mode_select)
      tfp_pkg::MODE_FAST_8, tfp_pkg::MODE_PHASE_8:
      begin
        top       = tfp_pkg::TOP_8BIT;  // see R2
        fixed_top = 1'b1;
      end
      tfp_pkg::MODE_FAST_9, tfp_pkg::MODE_PHASE_9:
      begin
        top       = tfp_pkg::TOP_9BIT;
        fixed_top = 1'b1;
      end
      tfp_pkg::MODE_FAST_10, tfp_pkg::MODE_PHASE_10:
      begin
        top       = tfp_pkg::TOP_10BIT;
        fixed_top = 1'b1;
      end
      tfp_pkg::MODE_FAST_CAP, tfp_pkg::MODE_PHASE_CAP:
        top = capture_top_register;  // see R8 see R13
      tfp_pkg::MODE_FAST_OCA, tfp_pkg::MODE_PHASE_OCA:
        top = compare_value_a;
      default:
        top = tfp_pkg::COUNT_MAX;
    endcase
    unique case (ctrl.waveform_mode_select)
      tfp_pkg::MODE_FAST_8, tfp_pkg::MODE_FAST_9, tfp_pkg::MODE_FAST_10,
      tfp_pkg::MODE_FAST_CAP, tfp_pkg::MODE_FAST_OCA:
        single_slope = 1'b1;  // see R1
      tfp_pkg::MODE_PHASE_8, tfp_pkg::MODE_PHASE_9, tfp_pkg::MODE_PHASE_10,
      tfp_pkg::MODE_PHASE_CAP, tfp_pkg::MODE_PHASE_OCA:
        dual_slope = 1'b1;  // see R13
      default:
        single_slope = 1'b0;
    endcase
  end

  // prescaler runs free; each selection taps its own low bits
  always_comb
  begin
    next_prescale = prescale + 10'h001;
    unique case (ctrl.clock_select)
      tfp_pkg::CS_DIV1:    tick = 1'b1;  // see R22
      tfp_pkg::CS_DIV8:    tick = (prescale & tfp_pkg::MASK_DIV8) == tfp_pkg::MASK_DIV8;
      tfp_pkg::CS_DIV64:   tick = (prescale & tfp_pkg::MASK_DIV64) == tfp_pkg::MASK_DIV64;
      tfp_pkg::CS_DIV256:  tick = (prescale & tfp_pkg::MASK_DIV256) == tfp_pkg::MASK_DIV256;
      tfp_pkg::CS_DIV1024: tick = prescale == tfp_pkg::MASK_DIV1024;
      default:             tick = 1'b0;
    endcase
  end

  always_comb
  begin
    at_top   = counter_value == top;
    match_a  = counter_value == compare_value_a;
    match_b  = counter_value == compare_value_b;
    // bottom counts as rising and top as falling, giving the flat extremes
    up_phase = (counter_value == tfp_pkg::WORD_RESET) || (!count_down && !at_top);
    setup    = psel && !penable;
    wr       = psel && penable && pready && pwrite;
    write_mask = fixed_top ? top : tfp_pkg::COUNT_MAX;  // see R9

    mapped    = 1'b1;
    read_word = 32'h0000_0000;
    unique case (paddr)
      tfp_pkg::CTRL_OFFSET:      read_word = {19'h00000, ctrl};
      tfp_pkg::COUNTER_OFFSET:   read_word = {16'h0000, counter_value};
      tfp_pkg::COMPARE_A_OFFSET: read_word = {16'h0000, compare_buf_a};
      tfp_pkg::COMPARE_B_OFFSET: read_word = {16'h0000, compare_buf_b};
      tfp_pkg::CAPTURE_OFFSET:   read_word = {16'h0000, capture_top_register};
      tfp_pkg::FLAGS_OFFSET:     read_word = {28'h0000000, flags};
      default:                   mapped = 1'b0;
    endcase

    // zero wait state: ready rises in the first access cycle
    next_pready  = setup;
    next_prdata  = setup ? read_word : 32'h0000_0000;
    next_pslverr = setup && !mapped;

    next_ctrl                 = ctrl;
    next_counter_value        = counter_value;
    next_count_down           = count_down;
    next_compare_buf_a        = compare_buf_a;
    next_compare_buf_b        = compare_buf_b;
    next_compare_value_a      = compare_value_a;
    next_compare_value_b      = compare_value_b;
    next_capture_top_register = capture_top_register;
    next_flags                = flags;
    next_compare_output_a     = compare_output_a;
    next_compare_output_b     = compare_output_b;

    if (wr)
    begin
      unique case (paddr)
        tfp_pkg::CTRL_OFFSET:
          next_ctrl = pwdata[12:0];
        tfp_pkg::COMPARE_A_OFFSET:
          next_compare_buf_a = pwdata[15:0] & write_mask;  // see R7 see R9
        tfp_pkg::COMPARE_B_OFFSET:
          next_compare_buf_b = pwdata[15:0] & write_mask;
        tfp_pkg::CAPTURE_OFFSET:
          next_capture_top_register = pwdata[15:0];  // see R8
        tfp_pkg::FLAGS_OFFSET:
          next_flags = flags & ~pwdata[3:0];  // see R25
        default:
          next_flags = next_flags;
      endcase
    end

    // outside the pwm modes the buffer is transparent and the counter rests
    if (!single_slope && !dual_slope)
    begin
      next_compare_value_a = next_compare_buf_a;
      next_compare_value_b = next_compare_buf_b;
      next_count_down      = 1'b0;
    end

    if (tick && (single_slope || dual_slope))
    begin
      if (match_a)
        next_flags[tfp_pkg::FLAG_COMPARE_A] = 1'b1;  // see R10
      if (match_b)
        next_flags[tfp_pkg::FLAG_COMPARE_B] = 1'b1;  // see R10

      if (single_slope)
      begin
        next_compare_output_a = wave(compare_output_a, ctrl.channel_a_output_mode,
          match_a, 1'b1, at_top, 1'b1,
          ctrl.waveform_mode_select == tfp_pkg::MODE_FAST_OCA);
        next_compare_output_b = wave(compare_output_b, ctrl.channel_b_output_mode,
          match_b, 1'b1, at_top, 1'b1, 1'b0);
        if (at_top)
        begin
          next_counter_value = tfp_pkg::WORD_RESET;  // see R3
          next_flags[tfp_pkg::FLAG_OVERFLOW] = 1'b1;  // see R6
          next_compare_value_a = compare_buf_a;  // see R7
          next_compare_value_b = compare_buf_b;
        end
        else
        begin
          // a top below the count is missed; the sum wraps through the maximum
          next_counter_value = counter_value + 16'h0001;  // see R1 see R8
        end
      end
      else
      begin
        next_compare_output_a = wave(compare_output_a, ctrl.channel_a_output_mode,
          match_a, 1'b0, 1'b0, up_phase,
          ctrl.waveform_mode_select == tfp_pkg::MODE_PHASE_OCA);
        next_compare_output_b = wave(compare_output_b, ctrl.channel_b_output_mode,
          match_b, 1'b0, 1'b0, up_phase, 1'b0);
        if (!count_down && at_top)
        begin
          // top was held through this whole tick
          next_count_down      = 1'b1;  // see R14
          next_counter_value   = counter_value - 16'h0001;
          next_compare_value_a = compare_buf_a;  // see R17
          next_compare_value_b = compare_buf_b;
        end
        else if (count_down && counter_value == tfp_pkg::WORD_RESET)
        begin
          next_count_down    = 1'b0;
          next_counter_value = 16'h0001;
          next_flags[tfp_pkg::FLAG_OVERFLOW] = 1'b1;  // see R16
        end
        else if (count_down)
        begin
          next_counter_value = counter_value - 16'h0001;  // see R13
        end
        else
        begin
          next_counter_value = counter_value + 16'h0001;
        end
      end

      // flag of the register that defines top, shared by both families
      if (at_top && (single_slope || !count_down))
      begin
        if (ctrl.waveform_mode_select == tfp_pkg::MODE_FAST_OCA ||
            ctrl.waveform_mode_select == tfp_pkg::MODE_PHASE_OCA)
          next_flags[tfp_pkg::FLAG_COMPARE_A] = 1'b1;  // see R6 see R16
        if (ctrl.waveform_mode_select == tfp_pkg::MODE_FAST_CAP ||
            ctrl.waveform_mode_select == tfp_pkg::MODE_PHASE_CAP)
          next_flags[tfp_pkg::FLAG_CAPTURE] = 1'b1;  // see R6 see R16
      end
    end

    // a software write of the count overrides the tick
    if (wr && paddr == tfp_pkg::COUNTER_OFFSET)
      next_counter_value = pwdata[15:0];

    // pin shows the compare output only when an output mode is active
    next_pin_a = (next_ctrl.channel_a_output_mode != tfp_pkg::COM_OFF) &&
                 next_compare_output_a;
    next_pin_b = (next_ctrl.channel_b_output_mode != tfp_pkg::COM_OFF) &&
                 next_compare_output_b;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl                 <= tfp_pkg::CTRL_RESET;
      counter_value        <= tfp_pkg::WORD_RESET;
      count_down           <= 1'b0;
      compare_buf_a        <= tfp_pkg::WORD_RESET;
      compare_buf_b        <= tfp_pkg::WORD_RESET;
      compare_value_a      <= tfp_pkg::WORD_RESET;
      compare_value_b      <= tfp_pkg::WORD_RESET;
      capture_top_register <= tfp_pkg::WORD_RESET;
      flags                <= 4'h0;
      compare_output_a     <= 1'b0;  // see R24
      compare_output_b     <= 1'b0;  // see R24
      prescale             <= 10'h000;
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
      compare_output_a_pin <= 1'b0;
      compare_output_a_oe  <= 1'b0;
      compare_output_b_pin <= 1'b0;
      compare_output_b_oe  <= 1'b0;
    end
    else
    begin
      ctrl                 <= next_ctrl;
      counter_value        <= next_counter_value;
      count_down           <= next_count_down;
      compare_buf_a        <= next_compare_buf_a;
      compare_buf_b        <= next_compare_buf_b;
      compare_value_a      <= next_compare_value_a;
      compare_value_b      <= next_compare_value_b;
      capture_top_register <= next_capture_top_register;
      flags                <= next_flags;
      compare_output_a     <= next_compare_output_a;
      compare_output_b     <= next_compare_output_b;
      prescale             <= next_prescale;
      prdata               <= next_prdata;
      pready               <= next_pready;
      pslverr              <= next_pslverr;
      compare_output_a_pin <= next_pin_a;
      compare_output_a_oe  <= next_ctrl.dir_a;  // see R21
      compare_output_b_pin <= next_pin_b;
      compare_output_b_oe  <= next_ctrl.dir_b;  // see R21
    end
  end

endmodule

`default_nettype wire

// >>> verif/tfp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

module tfp_pin_model (
  input  wire logic pin,
  input  wire logic oe,
  output wire logic pad
);
  // board pull-up: an undriven pad reads high, never the last driven value
  assign pad = oe ? pin : 1'b1;
endmodule

`default_nettype wire

// >>> verif/tfp_timer16_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module tfp_timer16_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        compare_output_a_pin,
  input wire logic        compare_output_a_oe,
  input wire logic        compare_output_b_pin,
  input wire logic        compare_output_b_oe
);
  wire logic mapped = paddr inside {tfp_pkg::CTRL_OFFSET, tfp_pkg::COUNTER_OFFSET,
    tfp_pkg::COMPARE_A_OFFSET, tfp_pkg::COMPARE_B_OFFSET, tfp_pkg::CAPTURE_OFFSET,
    tfp_pkg::FLAGS_OFFSET};
  wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == tfp_pkg::CTRL_OFFSET;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not idle");
  a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access flagged");
  a_dir_a_oe: assert property (ctrl_wr |=> compare_output_a_oe == $past(pwdata[11]))
    else $error("enable a does not follow direction");
  a_dir_b_oe: assert property (ctrl_wr |=> compare_output_b_oe == $past(pwdata[12]))
    else $error("enable b does not follow direction");
  a_off_mode_low: assert property (ctrl_wr && pwdata[5:4] == 2'h0 |-> ##2 !compare_output_a_pin)
    else $error("pin a active with output mode off");
  a_reset_pins_low: assert property ($rose(presetn) |-> !compare_output_a_pin
    && !compare_output_b_pin && !compare_output_a_oe && !compare_output_b_oe)
    else $error("pins not cleared by reset");

  c_ctrl_write: cover property (ctrl_wr);
  c_bus_error: cover property (pslverr);
  c_pin_rise: cover property ($rose(compare_output_a_pin));
endmodule

bind tfp_timer16 tfp_timer16_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .compare_output_a_pin(compare_output_a_pin),
  .compare_output_a_oe(compare_output_a_oe), .compare_output_b_pin(compare_output_b_pin),
  .compare_output_b_oe(compare_output_b_oe));

`default_nettype wire

// >>> verif/tb_timer16_fast_and_phase_pwm.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module tb_timer16_fast_and_phase_pwm;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  logic [31:0] prdata;
  wire  logic        pready;
  wire  logic        pslverr;
  wire  logic        pa;
  wire  logic        oa;
  wire  logic        pb;
  wire  logic        ob;
  wire  logic        pad_a;
  wire  logic        pad_b;
  int          errors = 0;
  int          check_count = 0;
  logic [31:0] rd;
  logic        er;
  logic [15:0] s [8];

  always #50 pclk = ~pclk;

  tfp_timer16 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_output_a_pin(pa), .compare_output_a_oe(oa),
    .compare_output_b_pin(pb), .compare_output_b_oe(ob));
  tfp_pin_model pin_a (.pin(pa), .oe(oa), .pad(pad_a));
  tfp_pin_model pin_b (.pin(pb), .oe(ob), .pad(pad_b));

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // leaves psel high so a following call runs back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle(1);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    idle(1);
  endtask

  // counter snapshots two clocks apart
  task automatic sample;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, tfp_pkg::COUNTER_OFFSET, 32'h0);
      s[i] = rd[15:0];
    end
    idle(1);
  endtask

  function automatic logic [31:0] ctrl(logic [3:0] m, logic [1:0] c, logic [2:0] cs, logic da);
    tfp_pkg::tfp_ctrl_type t;
    t = '{dir_b: 1'b1, dir_a: da, clock_select: cs, channel_b_output_mode: c,
          channel_a_output_mode: c, waveform_mode_select: m};
    return {19'h0, t};
  endfunction

  task automatic setup(input logic [15:0] ca, input logic [15:0] cnt);
    wr(tfp_pkg::CTRL_OFFSET, ctrl(4'h0, tfp_pkg::COM_OFF, 3'h0, 1'b1));
    wr(tfp_pkg::COMPARE_A_OFFSET, {16'h0, ca});
    wr(tfp_pkg::COUNTER_OFFSET, {16'h0, cnt});
    wr(tfp_pkg::FLAGS_OFFSET, 32'h0000000F);
  endtask

  task automatic pwm_case(input logic [3:0] m, input logic [1:0] c, input logic [15:0] cmp,
                          input logic da, input int n, input int ex);
    logic [15:0] ha;
    logic [15:0] hb;
    ha = 0;
    hb = 0;
    setup(cmp, 16'h0000);
    wr(tfp_pkg::COMPARE_B_OFFSET, {16'h0, cmp});
    wr(tfp_pkg::CTRL_OFFSET, ctrl(m, c, tfp_pkg::CS_DIV1, da));
    idle(520);
    repeat (n)
    begin
      @(negedge pclk);
      ha += pad_a;
      hb += pad_b;
    end
    `CHK("pad a high count", ex, ha)
    if (c != tfp_pkg::COM_TOGGLE && da)
      `CHK("pad b high count", ex, hb)
  endtask

  initial
  begin
    #8000000;
    errors++;
    final_report();
  end

  initial
  begin
    logic [7:0]  offs [6];
    logic [3:0]  mm [6];
    logic [15:0] tt [6];
    logic [15:0] v0;
    int          div;
    int          top1;
    int          mx;
    int          d;
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    mm = '{tfp_pkg::MODE_FAST_8, tfp_pkg::MODE_FAST_9, tfp_pkg::MODE_FAST_10,
           tfp_pkg::MODE_PHASE_8, tfp_pkg::MODE_PHASE_9, tfp_pkg::MODE_PHASE_10};
    tt = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h00FF, 16'h01FF, 16'h03FF};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i])
    begin
      rdr(offs[i]);
      `CHK("reset value", 32'h0, rd)
    end
    rdr(8'h18);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    foreach (mm[i])
    begin
      wr(tfp_pkg::CTRL_OFFSET, ctrl(mm[i], tfp_pkg::COM_OFF, 3'h0, 1'b1));
      wr(tfp_pkg::COMPARE_A_OFFSET, 32'h0000FFFF);
      rdr(tfp_pkg::COMPARE_A_OFFSET);
      `CHK("masked compare", {16'h0, tt[i]}, rd)
    end
    for (int cs = 1; cs <= 5; cs++)
    begin
      div = (cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
      setup(16'h0000, 16'h0000);
      wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_FAST_10, tfp_pkg::COM_OFF, 3'(cs), 1'b1));
      apb(1'b0, tfp_pkg::COUNTER_OFFSET, 32'h0);
      v0 = rd[15:0];
      idle(4 * div - 2);
      rdr(tfp_pkg::COUNTER_OFFSET);
      `CHK("ticks per span", 16'h0004, 16'(rd[15:0] - v0))
    end
    setup(16'h0005, 16'h0000);
    wr(tfp_pkg::COMPARE_B_OFFSET, 32'h00000002);
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_FAST_OCA, 2'h2, tfp_pkg::CS_DIV1, 1'b1));
    sample();
    for (int i = 1; i < 8; i++)
      `CHK("fast sequence", 16'((s[i-1] + 2) % 6), s[i])
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_FAST_OCA, 2'h2, 3'h0, 1'b1));
    rdr(tfp_pkg::FLAGS_OFFSET);
    `CHK("fast flags", 4'h7, rd[3:0])
    rdr(tfp_pkg::FLAGS_OFFSET);
    `CHK("flags held", 4'h7, rd[3:0])
    wr(tfp_pkg::COUNTER_OFFSET, 32'h00000004);
    wr(tfp_pkg::COMPARE_A_OFFSET, 32'h00000009);
    wr(tfp_pkg::FLAGS_OFFSET, 32'h0000000F);
    rdr(tfp_pkg::FLAGS_OFFSET);
    `CHK("flags cleared", 4'h0, rd[3:0])
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_FAST_OCA, 2'h2, tfp_pkg::CS_DIV1, 1'b1));
    sample();
    top1 = -1;
    mx = 0;
    for (int i = 1; i < 8; i++)
    begin
      if (s[i] < s[i-1] && top1 < 0)
        top1 = s[i-1];
      if (top1 >= 0 && s[i] > mx)
        mx = s[i];
    end
    `CHK("old top kept", 1'b1, top1 >= 0 && top1 <= 5)
    `CHK("new top used", 1'b1, mx > 5 && mx <= 9)
    setup(16'h0005, 16'hFFF8);
    wr(tfp_pkg::CAPTURE_OFFSET, 32'h00000008);
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_FAST_CAP, 2'h2, tfp_pkg::CS_DIV1, 1'b1));
    sample();
    `CHK("missed capture top", 1'b1, s[0] >= 16'hFFF8)
    `CHK("wrapped under top", 1'b1, s[7] <= 16'h0008)
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_FAST_CAP, 2'h2, 3'h0, 1'b1));
    rdr(tfp_pkg::FLAGS_OFFSET);
    `CHK("capture flags", 2'b11, {rd[3], rd[0]})
    setup(16'h0005, 16'h0000);
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_PHASE_OCA, 2'h2, tfp_pkg::CS_DIV1, 1'b1));
    sample();
    mx = 0;
    for (int i = 1; i < 8; i++)
    begin
      d = (s[i] > 5) ? 9 : int'(s[i]) - int'(s[i-1]);
      mx += (d < 0);
      `CHK("dual step", 1'b1, d inside {2, -2} || (d == 0 && s[i] inside {1, 4}))
    end
    `CHK("counts down", 1'b1, mx > 0)
    wr(tfp_pkg::CTRL_OFFSET, ctrl(tfp_pkg::MODE_PHASE_OCA, 2'h2, 3'h0, 1'b1));
    rdr(tfp_pkg::FLAGS_OFFSET);
    `CHK("dual flags", 2'b11, rd[1:0])
    pwm_case(tfp_pkg::MODE_FAST_8, 2'h2, 16'h0040, 1'b1, 1024, 764);
    pwm_case(tfp_pkg::MODE_FAST_8, 2'h3, 16'h0040, 1'b1, 1024, 260);
    pwm_case(tfp_pkg::MODE_FAST_8, 2'h2, 16'h0000, 1'b1, 1024, 1020);
    pwm_case(tfp_pkg::MODE_FAST_8, 2'h2, 16'h00FF, 1'b1, 1024, 1024);
    pwm_case(tfp_pkg::MODE_FAST_8, 2'h3, 16'h00FF, 1'b0, 1024, 1024);
    pwm_case(tfp_pkg::MODE_FAST_8, 2'h0, 16'h0040, 1'b1, 1024, 0);
    pwm_case(tfp_pkg::MODE_PHASE_8, 2'h2, 16'h0040, 1'b1, 2040, 512);
    pwm_case(tfp_pkg::MODE_PHASE_8, 2'h3, 16'h0040, 1'b1, 2040, 1528);
    pwm_case(tfp_pkg::MODE_PHASE_8, 2'h2, 16'h0000, 1'b1, 2040, 0);
    pwm_case(tfp_pkg::MODE_PHASE_8, 2'h2, 16'h00FF, 1'b1, 2040, 2040);
    pwm_case(tfp_pkg::MODE_FAST_OCA, 2'h1, 16'h0005, 1'b1, 1200, 600);
    pwm_case(tfp_pkg::MODE_PHASE_OCA, 2'h1, 16'h0005, 1'b1, 1000, 500);
    pwm_case(tfp_pkg::MODE_PHASE_CAP, 2'h2, 16'h0002, 1'b1, 160, 40);
    final_report();
  end
endmodule

`default_nettype wire
